// ==== rerm_regs.sv ====
// rail enable and mode control register bank with enable combination
`timescale 1ns/1ps
`default_nettype none
`include "rerm_defs.svh"

module rerm_regs
(
    // clock and reset
    input  wire logic                          clock,
    input  wire logic                          sys_rst,

    // one-time-programmed reset values, sampled while reset is high
    input  wire logic [7:0]                    otp_ldo_c_codes,
    input  wire logic [5:0]                    otp_buck_ctrl,

    // byte register port from the serial interface front end
    input  wire logic                          reg_wr_en,
    input  wire logic                          reg_rd_en,
    input  wire logic [`RERM_ADDR_W-1:0]       reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata,
    output logic                               reg_rd_valid,
    output logic                               reg_wr_ack,

    // pins and sequencer requests
    input  wire logic                          standby_sleep_pin_n,
    input  wire logic                          ldo_switch_enable_pin,
    input  wire logic                          switch_a_enable_pin,
    input  wire logic [`RERM_NUM_BUCK-1:0]     seq_rail_req,

    // regulator controls
    output logic      [`RERM_NUM_BUCK-1:0]     rail_enable,
    output logic      [2:0]                    rail_mode_pwm,
    output logic                               ldo_b_enable,
    output logic                               switch_a_enable,
    output logic      [`RERM_LDO_CODE_W-1:0]   ldo_c_vsel_code,
    output logic                               ldo_c_in_sleep
);

    // ============================================================
    // register storage and decode
    logic [`RERM_LDO_CODE_W-1:0]   ldo_c_sleep_code_r;
    logic [`RERM_LDO_CODE_W-1:0]   ldo_c_normal_code_r;
    logic [5:0]                    buck_ctrl_r;
    logic [7:0]                    force_en_r;
    logic [7:0]                    rdata_nxt;
    logic                          hit_ldo;
    logic                          hit_ctrl;
    logic                          hit_fen;

    // register fields as named signals
    logic [2:0]                    rail_force_off_n;
    logic [2:0]                    rail_mode_bits;
    logic [`RERM_NUM_BUCK-1:0]     rail_force_on;
    logic                          ldo_b_force_on;
    logic                          switch_a_force_on;

    // combined enables before the output flops
    logic [`RERM_NUM_BUCK-1:0]     rail_enable_nxt;
    logic                          ldo_b_enable_nxt;
    logic                          switch_a_enable_nxt;
    rerm_pkg::rerm_vsel_t          vsel_nxt;

    // address decode, shared by read and write
    assign hit_ldo  = (reg_addr == `RERM_OFS_LDO3_CODES);
    assign hit_ctrl = (reg_addr == `RERM_OFS_BUCK_CTRL);
    assign hit_fen  = (reg_addr == `RERM_OFS_FORCE_EN);

    // field aliases
    assign rail_force_off_n  = buck_ctrl_r[`RERM_CTRL_OFF_N_C:
                                           `RERM_CTRL_OFF_N_LSB];
    assign rail_mode_bits    = buck_ctrl_r[`RERM_CTRL_MODE_C:
                                           `RERM_CTRL_MODE_LSB];
    assign rail_force_on     = force_en_r[`RERM_FEN_BUCK_MSB:
                                          `RERM_FEN_BUCK_LSB];
    assign ldo_b_force_on    = force_en_r[`RERM_FEN_LDO_B];
    assign switch_a_force_on = force_en_r[`RERM_FEN_SWITCH_A];

    // ============================================================
    // ldo c voltage codes
    // reset loads the otp image; the reset is synchronous so taking a
    // port value here is safe, unlike an asynchronous clear
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ldo_c_sleep_code_r  <= otp_ldo_c_codes[`RERM_LDO_SLEEP_MSB:
                                                   `RERM_LDO_SLEEP_LSB];
            ldo_c_normal_code_r <= otp_ldo_c_codes[`RERM_LDO_NORMAL_MSB:
                                                   `RERM_LDO_NORMAL_LSB];
        end
        else if (reg_wr_en && hit_ldo)
        begin
            ldo_c_sleep_code_r  <= reg_wdata[`RERM_LDO_SLEEP_MSB:
                                             `RERM_LDO_SLEEP_LSB];
            ldo_c_normal_code_r <= reg_wdata[`RERM_LDO_NORMAL_MSB:
                                             `RERM_LDO_NORMAL_LSB];
        end
    end

    // ============================================================
    // buck mode and force-off control
    // only the six writable bits are stored, so bits 7:6 cannot stick
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            buck_ctrl_r <= otp_buck_ctrl;
        end
        else if (reg_wr_en && hit_ctrl)
        begin
            buck_ctrl_r <= reg_wdata[5:0];
        end
    end

    // ============================================================
    // force enable register
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            force_en_r <= `RERM_FEN_RESET;
        end
        else if (reg_wr_en && hit_fen)
        begin
            force_en_r <= reg_wdata;
        end
    end

    // ============================================================
    // read data mux; unmapped offsets answer with zero
    always_comb
    begin
        rdata_nxt = `RERM_UNMAPPED_DATA;
        case (1'b1)
            hit_ldo:
            begin
                rdata_nxt = {ldo_c_sleep_code_r, ldo_c_normal_code_r};
            end
            hit_ctrl:
            begin
                rdata_nxt = {2'h0, buck_ctrl_r};
            end
            hit_fen:
            begin
                rdata_nxt = force_en_r;
            end
            default:
            begin
                rdata_nxt = `RERM_UNMAPPED_DATA;
            end
        endcase
    end

    // read answer one cycle after the strobe; data holds until next read
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reg_rdata    <= 8'h00;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

    // write acknowledge, also given for unmapped offsets
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            reg_wr_ack <= 1'b0;
        end
        else
        begin
            reg_wr_ack <= reg_wr_en;
        end
    end

    // ============================================================
    // buck rail enable combination
    // rails a..c have an active-low off bit that wins over everything;
    // rails d..f have no off bit in this bank
    genvar gi;
    generate
        for (gi = 0; gi < `RERM_NUM_BUCK; gi++)
        begin : g_rail
            if (gi < `RERM_NUM_GUARDED)
            begin : g_guarded
                assign rail_enable_nxt[gi] = rail_force_off_n[gi] &
                    (rail_force_on[gi] | seq_rail_req[gi]);
            end
            else
            begin : g_free
                assign rail_enable_nxt[gi] = rail_force_on[gi] |
                    seq_rail_req[gi];
            end
        end
    endgenerate

    // ldo b and switch a follow their pins unless forced on
    assign ldo_b_enable_nxt    = ldo_b_force_on |
                                 ldo_switch_enable_pin;
    assign switch_a_enable_nxt = switch_a_force_on | ldo_switch_enable_pin |
                                 switch_a_enable_pin;

    // low standby pin selects the sleep code
    assign vsel_nxt = standby_sleep_pin_n ? rerm_pkg::RERM_VSEL_NORMAL :
                                            rerm_pkg::RERM_VSEL_SLEEP;

    // ============================================================
    // registered enables, recomputed every cycle; one cycle of latency
    // is traded for glitch-free outputs to the analog side
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rail_enable     <= '0;
            ldo_b_enable    <= 1'b0;
            switch_a_enable <= 1'b0;
        end
        else
        begin
            rail_enable     <= rail_enable_nxt;
            ldo_b_enable    <= ldo_b_enable_nxt;
            switch_a_enable <= switch_a_enable_nxt;
        end
    end

    // ============================================================
    // mode select outputs, one bit per guarded rail
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            rail_mode_pwm <= 3'h0;
        end
        else
        begin
            rail_mode_pwm <= rail_mode_bits;
        end
    end

    // ============================================================
    // ldo c voltage code selection
    // sleep and normal codes are kept apart so software can prepare the
    // sleep level ahead; equal codes disable the feature in effect
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            ldo_c_vsel_code <= 4'h0;
            ldo_c_in_sleep  <= 1'b0;
        end
        else
        begin
            case (vsel_nxt)
                rerm_pkg::RERM_VSEL_SLEEP:
                begin
                    ldo_c_vsel_code <= ldo_c_sleep_code_r;
                    ldo_c_in_sleep  <= 1'b1;
                end
                rerm_pkg::RERM_VSEL_NORMAL:
                begin
                    ldo_c_vsel_code <= ldo_c_normal_code_r;
                    ldo_c_in_sleep  <= 1'b0;
                end
                default:
                begin
                    ldo_c_vsel_code <= ldo_c_normal_code_r;
                    ldo_c_in_sleep  <= 1'b0;
                end
            endcase
        end
    end

endmodule : rerm_regs
`default_nettype wire

// ==== rerm_defs.svh ====
// register offsets, field positions and reset values of the rail control bank
`ifndef RERM_DEFS_SVH
`define RERM_DEFS_SVH

// ============================================================
// register offsets (byte addresses on the register port)
`define RERM_ADDR_W            8
`define RERM_OFS_LDO3_CODES    8'h9b
`define RERM_OFS_BUCK_CTRL     8'h9c
`define RERM_OFS_FORCE_EN      8'h9e

// ============================================================
// ldo3_voltage_codes fields
`define RERM_LDO_CODE_W        4
`define RERM_LDO_SLEEP_MSB     7
`define RERM_LDO_SLEEP_LSB     4
`define RERM_LDO_NORMAL_MSB    3
`define RERM_LDO_NORMAL_LSB    0

// ============================================================
// buck_mode_disable_ctrl fields
`define RERM_CTRL_RW_MASK      8'h3f
`define RERM_CTRL_MODE_C       5
`define RERM_CTRL_MODE_B       4
`define RERM_CTRL_MODE_A       3
`define RERM_CTRL_OFF_N_C      2
`define RERM_CTRL_OFF_N_B      1
`define RERM_CTRL_OFF_N_A      0
`define RERM_CTRL_MODE_LSB     3
`define RERM_CTRL_OFF_N_LSB    0

// ============================================================
// rail_force_enable fields and reset value
`define RERM_FEN_RESET         8'h00
`define RERM_FEN_LDO_B         7
`define RERM_FEN_SWITCH_A      6
`define RERM_FEN_BUCK_MSB      5
`define RERM_FEN_BUCK_LSB      0

// ============================================================
// answer to a read of an unmapped offset, and the counts of buck rails and guarded rails
`define RERM_UNMAPPED_DATA     8'h00
`define RERM_NUM_BUCK          6
`define RERM_NUM_GUARDED       3

`endif

// ==== rerm_pkg.sv ====
// types shared by the rail enable and mode register bank
`default_nettype none
package rerm_pkg;

    // ============================================================
    // switching mode of a buck rail, as held in the control register
    typedef enum logic
    {
        RERM_MODE_AUTO = 1'b0,
        RERM_MODE_PWM  = 1'b1
    } rerm_mode_t;

    // ============================================================
    // which ldo voltage code is being applied
    typedef enum logic
    {
        RERM_VSEL_NORMAL = 1'b0,
        RERM_VSEL_SLEEP  = 1'b1
    } rerm_vsel_t;

endpackage : rerm_pkg
`default_nettype wire

// ==== rerm_regs_monitor.sv ====
// concurrent checks on the ports of the rail control register bank
`timescale 1ns/1ps
`default_nettype none
module rerm_regs_monitor
(
    // clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // register port
    input wire logic       reg_wr_en,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_wr_ack,
    // pins and regulator controls
    input wire logic       standby_sleep_pin_n,
    input wire logic       ldo_switch_enable_pin,
    input wire logic       switch_a_enable_pin,
    input wire logic [5:0] rail_enable,
    input wire logic [2:0] rail_mode_pwm,
    input wire logic       ldo_b_enable,
    input wire logic       switch_a_enable,
    input wire logic       ldo_c_in_sleep
);
    // ============================================================
    // one clock domain, reset disables every check
    default clocking @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // a register write followed by a quiet cycle reaches the outputs
    wire ctrl_wr = reg_wr_en && reg_addr == 8'h9c;
    wire fen_wr  = reg_wr_en && reg_addr == 8'h9e;
    sequence s_ctrl_wr;
        ctrl_wr ##1 !ctrl_wr;
    endsequence
    sequence s_fen_wr;
        fen_wr ##1 !fen_wr;
    endsequence

    // ============================================================
    // properties
    property p_wr_ack;
        reg_wr_en |=> reg_wr_ack;
    endproperty
    property p_rsv_zero;
        reg_rd_en && reg_addr == 8'h9c |=> reg_rdata[7:6] == 2'b00;
    endproperty
    property p_sleep;
        !standby_sleep_pin_n |=> ldo_c_in_sleep;
    endproperty
    property p_ldo_b;
        ldo_switch_enable_pin |=> ldo_b_enable;
    endproperty
    property p_sw_a;
        ldo_switch_enable_pin || switch_a_enable_pin |=> switch_a_enable;
    endproperty
    property p_mode;
        s_ctrl_wr |=> rail_mode_pwm == $past(reg_wdata[5:3], 2);
    endproperty
    property p_off;
        s_ctrl_wr |=> (rail_enable[2:0] & ~$past(reg_wdata[2:0], 2)) == 3'h0;
    endproperty
    property p_fen;
        s_fen_wr |=> (rail_enable[5:3] & $past(reg_wdata[5:3], 2))
            == $past(reg_wdata[5:3], 2);
    endproperty

    a_wr_ack: assert property (p_wr_ack)
        else $error("write not acked");
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("bits 7:6 set");
    a_sleep: assert property (p_sleep)
        else $error("sleep code not used");
    a_ldo_b: assert property (p_ldo_b)
        else $error("ldo b not on");
    a_sw_a: assert property (p_sw_a)
        else $error("switch a not on");
    a_mode: assert property (p_mode)
        else $error("mode mismatch");
    a_off: assert property (p_off)
        else $error("rail not forced off");
    a_fen: assert property (p_fen)
        else $error("rail not forced on");
endmodule : rerm_regs_monitor

bind rerm_regs rerm_regs_monitor u_mon
(
    .clock, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_wr_ack, .standby_sleep_pin_n, .ldo_switch_enable_pin,
    .switch_a_enable_pin, .rail_enable, .rail_mode_pwm, .ldo_b_enable,
    .switch_a_enable, .ldo_c_in_sleep
);
`default_nettype wire

// ==== rerm_host_model.sv ====
// host model driving the byte register port of the rail bank
`timescale 1ns/1ps
`default_nettype none
module rerm_host_model
(
    // clock
    input wire logic       clock,
    // register port, host side
    output var logic       reg_wr_en = 1'b0,
    output var logic       reg_rd_en = 1'b0,
    output var logic [7:0] reg_addr = 8'h00,
    output var logic [7:0] reg_wdata = 8'h00,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rd_valid
);
    // ============================================================
    // tasks are entered just after an edge and return just after one,
    // so a strobe held across back-to-back calls never changes at a clock edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
    endtask : wr

    // read data is taken in the cycle its valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(posedge clock);
        #1;
        d = reg_rd_valid ? reg_rdata : ~reg_rdata;
    endtask : rd

    // released lines show the inverse so stale values are never trusted
    task automatic idle();
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = ~reg_addr;
        reg_wdata = ~reg_wdata;
        @(posedge clock);
        #1;
    endtask : idle
endmodule : rerm_host_model
`default_nettype wire

// ==== tb_rerm_regs.sv ====
// self-checking testbench of the rail control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_rerm_regs;
    // ============================================================
    // design signals, named as the ports so instances connect by name
    logic       clock = 1'b0;
    logic       sys_rst = 1'b1;
    logic [7:0] otp_ldo_c_codes = 8'h00;
    logic [5:0] otp_buck_ctrl = 6'h00;
    logic       reg_wr_en, reg_rd_en, reg_rd_valid, reg_wr_ack;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       standby_sleep_pin_n = 1'b1;
    logic       ldo_switch_enable_pin = 1'b0;
    logic       switch_a_enable_pin = 1'b0;
    logic [5:0] seq_rail_req = 6'h00;
    logic [5:0] rail_enable;
    logic [2:0] rail_mode_pwm;
    logic       ldo_b_enable, switch_a_enable, ldo_c_in_sleep;
    logic [3:0] ldo_c_vsel_code;
    int         errors = 0;
    int         n_tests = 0;
    logic [31:0] rs = 32'h8;
    logic [7:0] got, c, f, d;
    logic [8:0] p;
    logic [5:0] e;

    rerm_regs uut
    (
        .clock, .sys_rst, .otp_ldo_c_codes, .otp_buck_ctrl, .reg_wr_en,
        .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid,
        .reg_wr_ack, .standby_sleep_pin_n, .ldo_switch_enable_pin,
        .switch_a_enable_pin, .seq_rail_req, .rail_enable, .rail_mode_pwm,
        .ldo_b_enable, .switch_a_enable, .ldo_c_vsel_code, .ldo_c_in_sleep
    );
    rerm_host_model u_host
    (
        .clock, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rd_valid
    );

    // ============================================================
    // helpers: xorshift source, expected rails, compare and verdict
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd

    // force-off beats force-on and sequencer; rails d..f have no off bit
    function automatic logic [5:0] exp_rail(logic [7:0] cr, logic [7:0] fr,
                                            logic [5:0] s);
        return {fr[5:3] | s[5:3], cr[2:0] & (fr[2:0] | s[2:0])};
    endfunction : exp_rail

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : complete_run

    // ============================================================
    // clock, watchdog well past the ~460 cycles the sequence needs
    always #2 clock = ~clock;
    initial
    begin
        repeat (5000) @(posedge clock);
        errors++;
        complete_run();
    end

    // main sequence: reset images, then random and corner register sets
    initial
    begin
        otp_ldo_c_codes = 8'(rnd());
        otp_buck_ctrl = 6'(rnd());
        repeat (10) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        u_host.rd(8'h9b, got);
        chk(got, otp_ldo_c_codes);
        u_host.rd(8'h9c, got);
        chk(got, {2'b00, otp_buck_ctrl});
        u_host.rd(8'h9e, got);
        chk(got, 8'h00);
        for (int i = 0; i < 40; i++)
        begin
            c = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(rnd());
            f = (i < 2) ? ~c : 8'(rnd());
            d = 8'(rnd());
            u_host.wr(8'h9b, d);
            u_host.wr(8'h9c, c);
            u_host.wr(8'h9e, f);
            u_host.wr(8'h9d, ~c);
            u_host.rd(8'h9b, got);
            chk(got, d);
            u_host.rd(8'h9c, got);
            chk(got, c & 8'h3f);
            u_host.rd(8'h9e, got);
            chk(got, f);
            u_host.rd(8'h9d, got);
            chk(got, 8'h00);
            u_host.idle();
            p = 9'(rnd());
            {standby_sleep_pin_n, ldo_switch_enable_pin} = p[8:7];
            {switch_a_enable_pin, seq_rail_req} = p[6:0];
            repeat (2) @(posedge clock);
            #1;
            e = exp_rail(c, f, p[5:0]);
            chk(rail_enable[0], e[0]);
            chk(rail_enable[1], e[1]);
            chk(rail_enable[2], e[2]);
            chk(rail_enable[5:3], e[5:3]);
            chk(rail_mode_pwm[0], c[3]);
            chk(rail_mode_pwm[1], c[4]);
            chk(rail_mode_pwm[2], c[5]);
            chk(ldo_b_enable, f[7] | p[7]);
            chk(switch_a_enable, f[6] | p[7] | p[6]);
            chk(ldo_c_vsel_code, p[8] ? d[3:0] : d[7:4]);
            chk(ldo_c_in_sleep, !p[8]);
        end
        // mid-run reset with fresh images: written values must give way
        otp_ldo_c_codes = 8'(rnd());
        otp_buck_ctrl = 6'(rnd());
        sys_rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        chk(rail_enable, 6'h00);
        u_host.rd(8'h9e, got);
        chk(got, 8'h00);
        u_host.rd(8'h9c, got);
        chk(got, {2'b00, otp_buck_ctrl});
        u_host.rd(8'h9b, got);
        chk(got, otp_ldo_c_codes);
        u_host.idle();
        complete_run();
    end
endmodule : tb_rerm_regs
`default_nettype wire
